/* File: core/rhbsg_consts.svh */
// Constants for the timekeeping host port: decode bounds, divider and delay counts.
// Assumes a 20 MHz system clock.
`ifndef RHBSG_CONSTS_SVH
`define RHBSG_CONSTS_SVH
`define RHBSG_ADDR_W        17
`define RHBSG_INT_LAST      17'h0003F
`define RHBSG_RAM_LAST      17'h1FFFF
`define RHBSG_CLK_HZ        20000000
`define RHBSG_SQW_HZ        1024
`define RHBSG_SQW_HALF      (`RHBSG_CLK_HZ / (2 * `RHBSG_SQW_HZ))
`define RHBSG_REC_MS        150
`define RHBSG_REC_CYC       (`RHBSG_REC_MS * (`RHBSG_CLK_HZ / 1000))
`define RHBSG_PULSE_CYC     16'h0040
`endif

/* File: core/rhbsg_pkg.sv */
// Types shared by the host port files.
// Assumes rhbsg_consts.svh is available on the include path.
package rhbsg_pkg;
   typedef logic [7:0] rhbsg_byte_t;
   typedef enum logic [2:0] {
      RHBSG_PWR_FAIL = 3'h1,
      RHBSG_PWR_REC  = 3'h2,
      RHBSG_PWR_GOOD = 3'h4
   } rhbsg_pwr_e;
endpackage : rhbsg_pkg

/* File: core/rhbsg_regfile.sv */
// Sixty-four byte register store reached from the host port.
// Assumes write and read strobes are one-cycle pulses in the clk_i domain.
`timescale 1ns/1ns
module rhbsg_regfile #(
   parameter int DEPTH = 64
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   // Access
   input  wire logic                 wr_i,
   input  wire logic [5:0]           idx_i,
   input  wire rhbsg_pkg::rhbsg_byte_t wdata_i,
   output      rhbsg_pkg::rhbsg_byte_t rdata_o
);
   initial begin
      if (DEPTH != 64) $error("rhbsg_regfile: DEPTH must be 64");
   end
   rhbsg_pkg::rhbsg_byte_t mem_q [DEPTH];

   // Storage; contents are undefined after power-up as in any RAM
   always_ff @(posedge clk_i) begin
      if (wr_i) mem_q[idx_i] <= wdata_i;
   end

   // Asynchronous read: the output follows the address combinationally, with no flop
   assign rdata_o = mem_q[idx_i];
endmodule : rhbsg_regfile

/* File: core/rhbsg_sqw.sv */
// Square-wave divider producing a 1024 Hz toggle from the system clock.
// Assumes enable_i is a level in the clk_i domain.
`timescale 1ns/1ns
`include "rhbsg_consts.svh"
module rhbsg_sqw #(
   parameter int HALF = `RHBSG_SQW_HALF
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic resetn_i,
   // Control and output
   input  wire logic enable_i,
   output      logic wave_o
);
   initial begin
      if (HALF < 1 || HALF > 65535) $error("rhbsg_sqw: HALF out of range");
   end
   logic [15:0] cnt_q;
   logic        tick;
   assign tick = (cnt_q == 16'(HALF - 1));

   // Divider runs only while enabled so the wave starts low on each enable
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q  <= 16'h0000;
         wave_o <= 1'b0;
      end else if (!enable_i) begin
         cnt_q  <= 16'h0000;
         wave_o <= 1'b0;
      end else if (tick) begin
         cnt_q  <= 16'h0000;
         wave_o <= ~wave_o;
      end else begin
         cnt_q  <= cnt_q + 16'h0001;
      end
   end
endmodule : rhbsg_sqw

/* File: core/rhbsg_top.sv */
// Host port of a timekeeping controller: decode, register access, SRAM gating,
// power-fail handling, square wave and interrupt routing.
// Assumes all host pins are synchronous to clk_i; alarm sources come from outside.
// Functional notes
// R1: Host addresses 0x00..0x3F reach the internal 64-byte register store.
// R2: With select low, a rising write strobe writes the data lines into the register.
// R3: With select low and write high, the register is driven only while read enable is low.
// R4: Select passes to the RAM select output when power is good, else that output is high.
// R5: Read enable passes to the RAM read enable only with good power, select and external address.
// R6: The host holds select low during every bus cycle, internal or external.
// R7: On an internal read the read enable gates the device's own data drivers.
// R8: On an external read the data lines stay undriven and the RAM gets the read enable.
// R9: The power-fail output goes low on write protection and rises after the recovery delay.
// R10: When enabled the square wave toggles at 1024 Hz, otherwise the pin is undriven.
// R11: The primary interrupt carries the chosen alarm and the secondary one the other.
// R12: The primary interrupt is either a fixed-length pulse or a held low level.
// R13: After power returns, write protection holds for 150 ms with power-fail still low.
// R14: Addresses 0x40 to 0x1FFFF select the external RAM over seventeen address bits.
// R15: A falling write strobe releases the data lines even if read enable is low.
// R16: Outside an enabled internal read, the data drivers stay released.
`timescale 1ns/1ns
`include "rhbsg_consts.svh"
module rhbsg_top #(
   parameter int REC_CYC   = `RHBSG_REC_CYC,
   parameter int SQW_HALF  = `RHBSG_SQW_HALF
) (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         resetn_i,
   // Host bus
   input  wire logic [`RHBSG_ADDR_W-1:0]     addr_i,
   input  wire logic                         chip_select_n_i,
   input  wire logic                         output_enable_n_i,
   input  wire logic                         write_strobe_n_i,
   input  wire rhbsg_pkg::rhbsg_byte_t       data_lines_i,
   output      rhbsg_pkg::rhbsg_byte_t       data_lines_o,
   output      logic                         data_lines_oe_o,
   // External SRAM controls
   output      logic                         ram_select_out_n_o,
   output      logic                         ram_read_enable_out_n_o,
   // Power supervision
   input  wire logic                         supply_good_i,
   output      logic                         power_fail_out_n_o,
   // Square wave
   input  wire logic                         sqw_enable_i,
   output      logic                         square_wave_out_o,
   output      logic                         square_wave_out_oe_o,
   // Interrupts
   input  wire logic                         tod_alarm_i,
   input  wire logic                         wdog_alarm_i,
   input  wire logic                         irq_swap_i,
   input  wire logic                         irq_pulse_mode_i,
   output      logic                         irq_primary_n_o,
   output      logic                         irq_secondary_n_o
);
   initial begin
      if (REC_CYC < 1) $error("rhbsg_top: REC_CYC must be positive");
   end

   // Address decode shared by read, write and RAM gating
   function automatic logic is_internal(input logic [`RHBSG_ADDR_W-1:0] a);
      return a <= `RHBSG_INT_LAST;
   endfunction : is_internal

   // Power state machine
   rhbsg_pkg::rhbsg_pwr_e pwr_q, pwr_d;
   logic [31:0]           rec_cnt_q;
   logic                  rec_done;
   logic                  pwr_good;
   assign rec_done = (rec_cnt_q == 32'(REC_CYC - 1));
   assign pwr_good = (pwr_q == rhbsg_pkg::RHBSG_PWR_GOOD);

   // R13 recovery hold sequence
   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         rhbsg_pkg::RHBSG_PWR_FAIL: if (supply_good_i) pwr_d = rhbsg_pkg::RHBSG_PWR_REC;
         rhbsg_pkg::RHBSG_PWR_REC: begin
            if (!supply_good_i) pwr_d = rhbsg_pkg::RHBSG_PWR_FAIL;
            else if (rec_done) pwr_d = rhbsg_pkg::RHBSG_PWR_GOOD;
         end
         rhbsg_pkg::RHBSG_PWR_GOOD: if (!supply_good_i) pwr_d = rhbsg_pkg::RHBSG_PWR_FAIL;
         default: pwr_d = rhbsg_pkg::RHBSG_PWR_FAIL;
      endcase
   end

   // Reset counts as a power failure so the RAM starts protected
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pwr_q     <= rhbsg_pkg::RHBSG_PWR_FAIL;
         rec_cnt_q <= 32'h00000000;
      end else begin
         pwr_q     <= pwr_d;
         rec_cnt_q <= (pwr_q == rhbsg_pkg::RHBSG_PWR_REC) ? rec_cnt_q + 32'h00000001
                                                          : 32'h00000000;
      end
   end

   // Bus qualification; a failed supply blocks the select internally
   logic sel;
   logic internal;
   logic we_q;
   logic wr_rise;
   logic int_read;
   assign sel      = !chip_select_n_i && pwr_good;
   // R1 R14 internal versus external decode
   assign internal = is_internal(addr_i);
   // R2 write on rising strobe
   assign wr_rise  = sel && internal && !we_q && write_strobe_n_i;
   // R3 R7 R15 read only with write high
   assign int_read = sel && internal && write_strobe_n_i && !output_enable_n_i;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) we_q <= 1'b1;
      else           we_q <= write_strobe_n_i;
   end

   // Write data is captured while the strobe is low, the level the host holds at the edge
   rhbsg_pkg::rhbsg_byte_t wdata_q;
   logic [5:0]             widx_q;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wdata_q <= 8'h00;
         widx_q  <= 6'h00;
      end else if (!write_strobe_n_i) begin
         wdata_q <= data_lines_i;
         widx_q  <= addr_i[5:0];
      end
   end

   rhbsg_pkg::rhbsg_byte_t rdata;
   logic [5:0]             rf_idx;
   assign rf_idx = wr_rise ? widx_q : addr_i[5:0];

   rhbsg_regfile #(.DEPTH(64)) u_regs (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .wr_i     (wr_rise),
      .idx_i    (rf_idx),
      .wdata_i  (wdata_q),
      .rdata_o  (rdata)
   );

   // Data drivers and RAM controls, all registered
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_lines_o            <= 8'h00;
         data_lines_oe_o         <= 1'b0;
         ram_select_out_n_o      <= 1'b1;
         ram_read_enable_out_n_o <= 1'b1;
         power_fail_out_n_o      <= 1'b0;
      end else begin
         // R7 R8 R16 drivers only for internal reads
         data_lines_oe_o         <= int_read;
         data_lines_o            <= int_read ? rdata : 8'h00;
         // R4 select gating
         ram_select_out_n_o      <= !(sel && (pwr_d == rhbsg_pkg::RHBSG_PWR_GOOD));
         // R5 R8 read enable gating
         ram_read_enable_out_n_o <= !(sel && !internal && !output_enable_n_i &&
                                      (pwr_d == rhbsg_pkg::RHBSG_PWR_GOOD));
         // R9 power-fail output
         power_fail_out_n_o      <= (pwr_d == rhbsg_pkg::RHBSG_PWR_GOOD);
      end
   end

   // R10 square wave divider
   logic wave;
   rhbsg_sqw #(.HALF(SQW_HALF)) u_sqw (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .enable_i (sqw_enable_i),
      .wave_o   (wave)
   );

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         square_wave_out_o    <= 1'b0;
         square_wave_out_oe_o <= 1'b0;
      end else begin
         square_wave_out_o    <= sqw_enable_i ? wave : 1'b0;
         square_wave_out_oe_o <= sqw_enable_i;
      end
   end

   // R11 alarm routing
   logic prim_src;
   logic sec_src;
   logic prim_q;
   logic prim_rise;
   logic [15:0] pulse_cnt_q;
   assign prim_src  = irq_swap_i ? wdog_alarm_i : tod_alarm_i;
   assign sec_src   = irq_swap_i ? tod_alarm_i : wdog_alarm_i;
   assign prim_rise = prim_src && !prim_q;

   // R12 pulse or level on the primary output; pulse length is fixed, not level-tracked
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prim_q            <= 1'b0;
         pulse_cnt_q       <= 16'h0000;
         irq_primary_n_o   <= 1'b1;
         irq_secondary_n_o <= 1'b1;
      end else begin
         prim_q            <= prim_src;
         irq_secondary_n_o <= !sec_src;
         if (!irq_pulse_mode_i) begin
            pulse_cnt_q     <= 16'h0000;
            irq_primary_n_o <= !prim_src;
         end else if (prim_rise) begin
            pulse_cnt_q     <= `RHBSG_PULSE_CYC;
            irq_primary_n_o <= 1'b0;
         end else if (pulse_cnt_q > 16'h0001) begin
            pulse_cnt_q     <= pulse_cnt_q - 16'h0001;
         end else begin
            pulse_cnt_q     <= 16'h0000;
            irq_primary_n_o <= 1'b1;
         end
      end
   end

   // Checks on the data drivers, stated from the host pins and the internal terms pwr_good and internal

   // R16 drivers released without good power
   a_drv_release: assert property (@(posedge clk_i) disable iff (!resetn_i) // R16
      !pwr_good |=> !data_lines_oe_o) else $error("data driven outside read");
   // R15 write strobe releases bus
   a_we_release: assert property (@(posedge clk_i) disable iff (!resetn_i) // R15
      !write_strobe_n_i |=> !data_lines_oe_o) else $error("bus not released by write");
   // R3 R7 internal read drives bus
   a_int_drive: assert property (@(posedge clk_i) disable iff (!resetn_i) // R3 R7
      (pwr_good && !chip_select_n_i && internal && write_strobe_n_i && !output_enable_n_i)
      |=> data_lines_oe_o) else $error("internal read not driven");
   // R8 external address leaves bus
   a_ext_float: assert property (@(posedge clk_i) disable iff (!resetn_i) // R8
      !internal |=> !data_lines_oe_o) else $error("data driven on external addr");
   // R16 read enable high releases
   a_oe_release: assert property (@(posedge clk_i) disable iff (!resetn_i) // R16
      output_enable_n_i |=> !data_lines_oe_o) else $error("data driven without read enable");
   // R16 deselect releases the bus
   a_cs_release: assert property (@(posedge clk_i) disable iff (!resetn_i) // R16
      chip_select_n_i |=> !data_lines_oe_o) else $error("data driven without select");

   // Checks on the RAM controls

   // R4 select blocked without good power
   a_sel_block: assert property (@(posedge clk_i) disable iff (!resetn_i) // R4
      !supply_good_i |=> ram_select_out_n_o) else $error("ram select during fail");
   // R4 select passed with good power
   a_sel_pass: assert property (@(posedge clk_i) disable iff (!resetn_i) // R4
      (pwr_good && supply_good_i) |=> (ram_select_out_n_o == $past(chip_select_n_i)))
      else $error("ram select not passed");
   // R5 read enable blocked on internal address
   a_oer_internal: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
      internal |=> ram_read_enable_out_n_o) else $error("ram read on internal addr");
   // R5 R8 read enable passed externally
   a_oer_pass: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5 R8
      (pwr_good && supply_good_i && !internal && !chip_select_n_i)
      |=> (ram_read_enable_out_n_o == $past(output_enable_n_i))) else $error("ram read not passed");
   // R5 read enable needs select
   a_oer_cs: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
      chip_select_n_i |=> ram_read_enable_out_n_o) else $error("ram read without select");
   // R5 read enable blocked on fail
   a_oer_fail: assert property (@(posedge clk_i) disable iff (!resetn_i) // R5
      !supply_good_i |=> ram_read_enable_out_n_o) else $error("ram read during fail");

   // Checks on power supervision

   // R9 power-fail tracks write protection
   a_pfo_match: assert property (@(posedge clk_i) disable iff (!resetn_i) // R9
      ##1 (power_fail_out_n_o == pwr_good)) else $error("power fail mismatch");
   // R9 supply loss asserts power-fail
   a_pfo_fail: assert property (@(posedge clk_i) disable iff (!resetn_i) // R9
      !supply_good_i |=> !power_fail_out_n_o) else $error("power fail not asserted");
   // R13 recovery lasts the full count
   a_rec_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
      $rose(pwr_good) |-> $past(rec_done)) else $error("recovery cut short");
   // R13 recovery keeps RAM protected
   a_rec_protect: assert property (@(posedge clk_i) disable iff (!resetn_i) // R13
      (pwr_q == rhbsg_pkg::RHBSG_PWR_REC) |-> (ram_select_out_n_o && !power_fail_out_n_o))
      else $error("ram open during recovery");

   // Checks on interrupt routing and shape

   // R11 secondary carries other alarm
   a_irq_route: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11
      ##1 (irq_secondary_n_o == !$past(sec_src))) else $error("secondary routing wrong");
   // R11 secondary watchdog by default
   a_sec_wdog: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11
      !irq_swap_i |=> (irq_secondary_n_o == !$past(wdog_alarm_i))) else $error("secondary not wdog");
   // R11 secondary time of day swapped
   a_sec_tod: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11
      irq_swap_i |=> (irq_secondary_n_o == !$past(tod_alarm_i))) else $error("secondary not tod");
   // R11 R12 primary level time of day
   a_prim_tod: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11 R12
      (!irq_pulse_mode_i && !irq_swap_i) |=> (irq_primary_n_o == !$past(tod_alarm_i)))
      else $error("primary not tod level");
   // R11 R12 primary level watchdog
   a_prim_wdog: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11 R12
      (!irq_pulse_mode_i && irq_swap_i) |=> (irq_primary_n_o == !$past(wdog_alarm_i)))
      else $error("primary not wdog level");
   // R12 pulse mode holds the pulse
   a_irq_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
      (irq_pulse_mode_i && prim_rise) ##1 irq_pulse_mode_i [*8] |-> !irq_primary_n_o)
      else $error("pulse too short");
   // R12 pulse mode ends the pulse
   a_pulse_end: assert property (@(posedge clk_i) disable iff (!resetn_i) // R12
      (irq_pulse_mode_i && !prim_rise && pulse_cnt_q == 16'h0001) |=> irq_primary_n_o)
      else $error("pulse not ended");

   // Checks on the square-wave pin

   // R10 pin released when disabled
   a_sqw_off: assert property (@(posedge clk_i) disable iff (!resetn_i) // R10
      !sqw_enable_i |=> !square_wave_out_oe_o) else $error("square wave driven when off");
   // R10 pin driven when enabled
   a_sqw_on: assert property (@(posedge clk_i) disable iff (!resetn_i) // R10
      sqw_enable_i |=> square_wave_out_oe_o) else $error("square wave not driven");
   // R10 wave parked low when off
   a_sqw_low: assert property (@(posedge clk_i) disable iff (!resetn_i) // R10
      !sqw_enable_i |=> !square_wave_out_o) else $error("square wave not parked");
endmodule : rhbsg_top

/* File: dv/rhbsg_sram_model.sv */
// Behavioural model of the external static RAM behind the gated controls.
// Assumes host strobe, address and data are synchronous to clk_i.
`timescale 1ns/1ns
module rhbsg_sram_model (
   // Clock
   input  wire logic        clk_i,
   // Gated controls and host bus
   input  wire logic        ram_select_n_i,
   input  wire logic        ram_read_n_i,
   input  wire logic        write_strobe_n_i,
   input  wire logic [16:0] addr_i,
   input  wire logic [7:0]  data_i,
   // Read data towards the shared bus
   output      logic [7:0]  data_o,
   output      logic        data_oe_o
);
   logic [7:0]  mem_q [0:131071];
   logic        we_q = 1'b1;
   logic [7:0]  wd_q;
   logic [16:0] wa_q;

   // Drives only while both gated controls are low, as a real part does
   assign data_oe_o = !ram_select_n_i && !ram_read_n_i;
   assign data_o    = mem_q[addr_i];

   // Write lands on the rising strobe, and only while select is passed through
   always @(posedge clk_i) begin
      if (!write_strobe_n_i) begin
         wd_q <= data_i;
         wa_q <= addr_i;
      end
      if (!we_q && write_strobe_n_i && !ram_select_n_i) begin
         mem_q[wa_q] <= wd_q;
      end
      we_q <= write_strobe_n_i;
   end
endmodule : rhbsg_sram_model

/* File: dv/rtc_host_bus_sram_gating_tb.sv */
// Self-checking bench for the host port: register access, SRAM gating, power, wave, irqs.
// Assumes the design files in core/ and the RAM model are compiled first.
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end
module rtc_host_bus_sram_gating_tb;
   localparam int REC  = 20;
   localparam int HALF = 4;
   logic clk_i = 1'b0, resetn_i, cs_n, oe_n, we_n, supply, sqw_en, tod, wdog, swap, pmode;
   logic h_oe, s_oe, dut_oe, power_fail_out_n, sel_n, re_n, sqw, sqw_oe, irq_a, irq_b, oe_prev, w;
   logic [16:0] addr, ea;
   logic [7:0]  h_d, s_d, dut_d, bus, float_q = 8'hC3, d, e, m_e, mem_e [0:63];
   logic [7:0]  exp_q [$];
   int seed, i, k, cnt, miscompares = 0, comparisons = 0;

   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) float_q <= ~float_q;
   // Released bus shows a changing pattern, never the last driven value
   assign bus = dut_oe ? dut_d : s_oe ? s_d : h_oe ? h_d : float_q;

   rhbsg_top #(.REC_CYC(REC), .SQW_HALF(HALF)) rhbsg_top_inst (
      .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .chip_select_n_i(cs_n),
      .output_enable_n_i(oe_n), .write_strobe_n_i(we_n), .data_lines_i(bus),
      .data_lines_o(dut_d), .data_lines_oe_o(dut_oe), .ram_select_out_n_o(sel_n),
      .ram_read_enable_out_n_o(re_n), .supply_good_i(supply), .power_fail_out_n_o(power_fail_out_n),
      .sqw_enable_i(sqw_en), .square_wave_out_o(sqw), .square_wave_out_oe_o(sqw_oe),
      .tod_alarm_i(tod), .wdog_alarm_i(wdog), .irq_swap_i(swap), .irq_pulse_mode_i(pmode),
      .irq_primary_n_o(irq_a), .irq_secondary_n_o(irq_b));

   rhbsg_sram_model rhbsg_sram_model_inst (
      .clk_i(clk_i), .ram_select_n_i(sel_n), .ram_read_n_i(re_n), .write_strobe_n_i(we_n),
      .addr_i(addr), .data_i(bus), .data_o(s_d), .data_oe_o(s_oe));

   // Each rise of the drive enable takes the oldest expected read byte
   always @(negedge clk_i) begin
      if (dut_oe === 1'b1 && oe_prev !== 1'b1) begin
         m_e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
         `CHK(dut_d, m_e)
      end
      oe_prev = dut_oe;
   end

   // Host write cycle: select held low from address to past the rising strobe
   task automatic host_wr(input logic [16:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr <= a; cs_n <= 1'b0; we_n <= 1'b0; h_d <= v; h_oe <= 1'b1;
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK(dut_oe, 1'b0)
      @(posedge clk_i);
      we_n <= 1'b1;
      @(posedge clk_i);
      cs_n <= 1'b1; h_oe <= 1'b0;
   endtask : host_wr

   // Host read cycle: internal reads are noted for the monitor, external checked here
   task automatic host_rd(input logic [16:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr <= a; cs_n <= 1'b0; oe_n <= 1'b0;
      if (a <= 17'h0003F) exp_q.push_back(mem_e[a[5:0]]);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      v = bus;
      `CHK(re_n, (a > 17'h0003F) ? 1'b0 : 1'b1)
      if (a > 17'h0003F) begin
         `CHK(dut_oe, 1'b0)
         `CHK(sel_n, 1'b0)
      end
      @(posedge clk_i);
      cs_n <= 1'b1; oe_n <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHK(dut_oe, 1'b0)
   endtask : host_rd

   task print_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict

   initial begin
      #(50 * 40000);
      miscompares++;
      print_verdict();
   end

   initial begin
      seed = 80; resetn_i = 1'b0; addr = '0; cs_n = 1'b1; oe_n = 1'b1; we_n = 1'b1;
      h_d = '0; h_oe = 1'b0; supply = 1'b1; sqw_en = 1'b0; tod = 1'b0; wdog = 1'b0;
      swap = 1'b0; pmode = 1'b0;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (REC + 5) @(posedge clk_i);
      `CHK(power_fail_out_n, 1'b1)
      // Every internal location written with random bytes, then read back
      for (i = 0; i < 64; i++) begin
         mem_e[i] = 8'($random(seed));
         host_wr(i[16:0], mem_e[i]);
      end
      for (i = 0; i < 64; i++) host_rd(i[16:0], d);
      // External boundaries and one random address reach the RAM model
      for (k = 0; k < 3; k++) begin
         ea = (k == 0) ? 17'h00040 : (k == 1) ? 17'h1FFFF : 17'h00040 | 17'($random(seed));
         e = 8'($random(seed));
         host_wr(ea, e);
         host_rd(ea, d);
         `CHK(d, e)
      end
      // Falling strobe during an enabled read releases the data lines
      @(posedge clk_i);
      addr <= 17'h00005; cs_n <= 1'b0; oe_n <= 1'b0; exp_q.push_back(mem_e[5]);
      repeat (3) @(posedge clk_i);
      we_n <= 1'b0; h_d <= mem_e[5]; h_oe <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHK(dut_oe, 1'b0)
      we_n <= 1'b1;
      oe_n <= 1'b1;
      @(posedge clk_i);
      cs_n <= 1'b1; oe_n <= 1'b1; h_oe <= 1'b0;
      // Supply loss: RAM select held high, writes refused, recovery before access
      supply <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK(power_fail_out_n, 1'b0)
      host_wr(17'h00003, ~mem_e[3]);
      @(posedge clk_i);
      supply <= 1'b1; addr <= 17'h00100; cs_n <= 1'b0;
      repeat (REC - 3) @(posedge clk_i);
      `CHK(sel_n, 1'b1)
      `CHK(power_fail_out_n, 1'b0)
      repeat (8) @(posedge clk_i);
      `CHK(sel_n, 1'b0)
      cs_n <= 1'b1;
      host_rd(17'h00003, d);
      // Square wave half period and release of the pin
      sqw_en <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(sqw_oe, 1'b1)
      for (k = 0; k < 2; k++) begin
         w = sqw;
         cnt = 0;
         while (sqw === w && cnt < 50) begin
            @(negedge clk_i);
            cnt++;
         end
      end
      `CHK(cnt, HALF)
      @(posedge clk_i);
      sqw_en <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK(sqw_oe, 1'b0)
      `CHK(sqw, 1'b0)
      // Both routings with each alarm source in level mode
      for (k = 0; k < 4; k++) begin
         swap <= k[1]; tod <= !k[0]; wdog <= k[0];
         repeat (3) @(posedge clk_i);
         `CHK(irq_a, (k[0] == k[1]) ? 1'b0 : 1'b1)
         `CHK(irq_b, (k[0] == k[1]) ? 1'b1 : 1'b0)
         tod <= 1'b0; wdog <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
      // Pulse mode gives a fixed low width on a held alarm
      swap <= 1'b0; pmode <= 1'b1;
      repeat (3) @(posedge clk_i);
      tod <= 1'b1;
      cnt = 0;
      repeat (100) begin
         @(negedge clk_i);
         if (irq_a === 1'b0) cnt++;
      end
      `CHK(cnt, 64)
      `CHK(exp_q.size(), 0)
      print_verdict();
   end
endmodule : rtc_host_bus_sram_gating_tb
